// File: irq_bank_pkg.sv
// What this block does
// RULE_01: Flags set on events regardless of enables.
// RULE_02: Software clears flags before enabling and after service.
// RULE_03: Three 8-bit flag registers, reset to zero.
// RULE_04: Parallel port access sets flag one bit 7.
// RULE_05: Parallel port bits active only in on-chip mode.
// RULE_06: Conversion done sets bit 6; zero write clears.
// RULE_07: Bit 5 mirrors serial one receive full.
// RULE_08: Bit 4 mirrors serial one transmit empty.
// RULE_09: Sync serial completion sets flag one bit 3.
// RULE_10: Capture/compare one sets bit 2, not PWM.
// RULE_11: Timer two period match sets bit 1.
// RULE_12: Timer one overflow sets flag one bit 0.
// RULE_13: Flag two bits 7,5 zero; nvm, timer three.
// RULE_14: Comparator output change sets flag two bit 6.
// RULE_15: Collision during master transmit sets bit 3.
// RULE_16: Low voltage report sets flag two bit 2.
// RULE_17: Capture/compare two sets bit 0, not PWM.
// RULE_18: Flag three layout: serial two, timer four, units.
// RULE_19: Enable bit per flag, resets zero, gates request.
// RULE_20: Without priority levels, peripheral global enable gates.
// RULE_21: Core bits: peripheral enable 6, global enable 7.
// RULE_22: Core response clears global enable until return.
// RULE_23: Request is OR of flag AND enable.
// RULE_24: Hardware set beats software clear same cycle.
package irq_bank_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_FLAGS_ONE = 8'h00;
	localparam logic [7:0] OFS_FLAGS_TWO = 8'h04;
	localparam logic [7:0] OFS_FLAGS_THREE = 8'h08;
	localparam logic [7:0] OFS_ENABLES_ONE = 8'h0C;
	localparam logic [7:0] OFS_ENABLES_TWO = 8'h10;
	localparam logic [7:0] OFS_ENABLES_THREE = 8'h14;
	localparam logic [7:0] OFS_CORE_CONTROL = 8'h18;
	localparam logic [7:0] OFS_MODE_CONTROL = 8'h1C;

	// ==========================================================
	// Implemented and software-writable bits
	localparam logic [7:0] FLAGS_ONE_IMPL = 8'hFF;
	localparam logic [7:0] FLAGS_ONE_WR = 8'hCF;
	localparam logic [7:0] FLAGS_TWO_IMPL = 8'h5F;
	localparam logic [7:0] FLAGS_THREE_IMPL = 8'h3F;
	localparam logic [7:0] FLAGS_THREE_WR = 8'h0F;
	localparam logic [7:0] ENABLES_ONE_IMPL = 8'hFF;
	localparam logic [7:0] ENABLES_TWO_IMPL = 8'h5F;
	localparam logic [7:0] ENABLES_THREE_IMPL = 8'h3F;
	localparam logic [7:0] CORE_CONTROL_IMPL = 8'hC1;
	localparam logic [7:0] MODE_CONTROL_IMPL = 8'h01;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ==========================================================
	// Bit positions
	localparam int BIT_PSP = 7;
	localparam int BIT_RX = 5;
	localparam int BIT_TX = 4;
	localparam int BIT_PRIORITY_ON = 0;
	localparam int BIT_PERIPH_GLOBAL = 6;
	localparam int BIT_GLOBAL = 7;
	localparam int BIT_ONCHIP_MODE = 0;

	// ==========================================================
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Capture/compare unit modes
	typedef enum logic [1:0] {
		CCP_OFF = 2'b00,
		CCP_CAPTURE = 2'b01,
		CCP_COMPARE = 2'b10,
		CCP_PWM = 2'b11
	} ccp_mode_t;

	// Register selector from address decode
	typedef enum logic [3:0] {
		SEL_FLAGS_ONE = 4'b0000,
		SEL_FLAGS_TWO = 4'b0001,
		SEL_FLAGS_THREE = 4'b0010,
		SEL_ENABLES_ONE = 4'b0011,
		SEL_ENABLES_TWO = 4'b0100,
		SEL_ENABLES_THREE = 4'b0101,
		SEL_CORE_CONTROL = 4'b0110,
		SEL_MODE_CONTROL = 4'b0111,
		SEL_NONE = 4'b1000
	} reg_sel_t;

endpackage

// File: peripheral_irq_flag_enable_bank.sv
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module peripheral_irq_flag_enable_bank #(
	parameter bit HAS_EXT_MEM = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [irq_bank_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Peripheral event pulses, same clock
	input wire logic parallel_port_access,
	input wire logic conversion_done,
	input wire logic sync_serial_done,
	input wire logic timer_two_match,
	input wire logic timer_one_overflow,
	input wire logic nvm_write_done,
	input wire logic bus_collision,
	input wire logic i2c_master_transmitting,
	input wire logic low_voltage_detected,
	input wire logic timer_three_overflow,
	input wire logic timer_four_match,
	// Serial port buffer levels, same clock
	input wire logic serial_one_rx_full,
	input wire logic serial_one_tx_empty,
	input wire logic serial_two_rx_full,
	input wire logic serial_two_tx_empty,
	// Capture/compare units one..five, index 0 is unit one
	input wire logic [9:0] capcomp_mode,
	input wire logic [4:0] capcomp_capture,
	input wire logic [4:0] capcomp_compare,
	// Comparator output, asynchronous
	input wire logic comparator_out,
	// Core handshake pulses
	input wire logic core_irq_taken,
	input wire logic core_irq_return,
	// Requests toward the core
	output logic periph_request,
	output logic core_irq
);

	// ==========================================================
	// State
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic aw_got;
		logic w_got;
		logic [7:0] waddr;
		logic [7:0] wdata;
		logic wlane0;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] flags_one;
		logic [7:0] flags_two;
		logic [7:0] flags_three;
		logic [7:0] enables_one;
		logic [7:0] enables_two;
		logic [7:0] enables_three;
		logic [7:0] core_control;
		logic [7:0] mode_control;
		logic cmp_meta;
		logic cmp_sync;
		logic cmp_prev;
		logic cmp_primed;
		logic periph_request;
		logic core_irq;
	} state_t;

	state_t s_ff;
	state_t nxt_s;

	// ==========================================================
	// Helpers
	// Address to register selector
	function automatic irq_bank_pkg::reg_sel_t decode(
		input logic [7:0] addr
	);
		irq_bank_pkg::reg_sel_t sel;
		sel = irq_bank_pkg::SEL_NONE;
		unique case (addr)
			irq_bank_pkg::OFS_FLAGS_ONE: sel = irq_bank_pkg::SEL_FLAGS_ONE;
			irq_bank_pkg::OFS_FLAGS_TWO: sel = irq_bank_pkg::SEL_FLAGS_TWO;
			irq_bank_pkg::OFS_FLAGS_THREE:
				sel = irq_bank_pkg::SEL_FLAGS_THREE;
			irq_bank_pkg::OFS_ENABLES_ONE:
				sel = irq_bank_pkg::SEL_ENABLES_ONE;
			irq_bank_pkg::OFS_ENABLES_TWO:
				sel = irq_bank_pkg::SEL_ENABLES_TWO;
			irq_bank_pkg::OFS_ENABLES_THREE:
				sel = irq_bank_pkg::SEL_ENABLES_THREE;
			irq_bank_pkg::OFS_CORE_CONTROL:
				sel = irq_bank_pkg::SEL_CORE_CONTROL;
			irq_bank_pkg::OFS_MODE_CONTROL:
				sel = irq_bank_pkg::SEL_MODE_CONTROL;
			default: sel = irq_bank_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction

	// Write masked bits, then hardware sets on top
	function automatic logic [7:0] update_flags(
		input logic [7:0] cur,
		input logic [7:0] wmask,
		input logic [7:0] wval,
		input logic [7:0] hw_set,
		input logic [7:0] impl
	);
		return (((cur & ~wmask) | (wval & wmask)) | hw_set) & impl; // [RULE_24]
	endfunction

	// Capture event in capture mode, match in compare mode
	function automatic logic ccp_hit(
		input logic [1:0] mode,
		input logic cap,
		input logic cmp
	);
		return (mode == irq_bank_pkg::CCP_CAPTURE && cap) ||
			(mode == irq_bank_pkg::CCP_COMPARE && cmp);
	endfunction

	// ==========================================================
	// Event decode
	logic psp_active;
	logic cmp_changed;
	logic [4:0] ccp_set;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic [7:0] set_three;

	// Parallel port bits live only in on-chip mode on ext-mem parts
	assign psp_active = !HAS_EXT_MEM ||
		s_ff.mode_control[irq_bank_pkg::BIT_ONCHIP_MODE]; // [RULE_05]
	assign cmp_changed = s_ff.cmp_primed &&
		(s_ff.cmp_sync != s_ff.cmp_prev); // [RULE_14]

	// PWM and off modes raise nothing
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			ccp_set[i] = ccp_hit(capcomp_mode[2*i +: 2], capcomp_capture[i],
				capcomp_compare[i]); // [RULE_10] [RULE_17]
		end
	end

	// Hardware set vectors, independent of any enable
	always_comb begin
		set_one = {
			parallel_port_access && psp_active, // [RULE_04]
			conversion_done, // [RULE_06]
			1'b0,
			1'b0,
			sync_serial_done, // [RULE_09]
			ccp_set[0], // [RULE_10]
			timer_two_match, // [RULE_11]
			timer_one_overflow // [RULE_12]
		}; // [RULE_01]
		set_two = {
			1'b0,
			cmp_changed, // [RULE_14]
			1'b0,
			nvm_write_done, // [RULE_13]
			bus_collision && i2c_master_transmitting, // [RULE_15]
			low_voltage_detected, // [RULE_16]
			timer_three_overflow, // [RULE_13]
			ccp_set[1] // [RULE_17]
		};
		set_three = {
			2'b00,
			2'b00,
			timer_four_match,
			ccp_set[4],
			ccp_set[3],
			ccp_set[2]
		}; // [RULE_18]
	end

	// ==========================================================
	// Next state
	always_comb begin
		irq_bank_pkg::reg_sel_t wsel;
		irq_bank_pkg::reg_sel_t rsel;
		logic do_write;
		logic [7:0] wm_one;
		logic [7:0] wm_two;
		logic [7:0] wm_three;
		logic [7:0] pending;
		logic request;
		wsel = irq_bank_pkg::SEL_NONE;
		rsel = irq_bank_pkg::SEL_NONE;
		do_write = 1'b0;
		wm_one = irq_bank_pkg::RESET_BYTE;
		wm_two = irq_bank_pkg::RESET_BYTE;
		wm_three = irq_bank_pkg::RESET_BYTE;
		pending = irq_bank_pkg::RESET_BYTE;
		request = 1'b0;
		nxt_s = s_ff;

		// Comparator synchroniser and change history
		nxt_s.cmp_meta = comparator_out;
		nxt_s.cmp_sync = s_ff.cmp_meta;
		nxt_s.cmp_prev = s_ff.cmp_sync;
		nxt_s.cmp_primed = 1'b1;

		// Write response retires
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// Address and data taken in either order
		if (s_axi_awvalid && s_ff.awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.wdata = s_axi_wdata[7:0];
			nxt_s.wlane0 = s_axi_wstrb[0];
		end
		if (nxt_s.aw_got && nxt_s.w_got && !s_ff.bvalid) begin
			wsel = decode(nxt_s.waddr);
			do_write = nxt_s.wlane0;
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = (wsel == irq_bank_pkg::SEL_NONE) ?
				irq_bank_pkg::RESP_SLVERR : irq_bank_pkg::RESP_OKAY;
		end
		nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;

		// Flag write masks for software-writable bits
		if (do_write) begin
			if (wsel == irq_bank_pkg::SEL_FLAGS_ONE) begin
				wm_one = irq_bank_pkg::FLAGS_ONE_WR;
			end
			if (wsel == irq_bank_pkg::SEL_FLAGS_TWO) begin
				wm_two = irq_bank_pkg::FLAGS_TWO_IMPL;
			end
			if (wsel == irq_bank_pkg::SEL_FLAGS_THREE) begin
				wm_three = irq_bank_pkg::FLAGS_THREE_WR;
			end
		end

		// Flag registers: clear by zero write, set wins
		nxt_s.flags_one = update_flags(s_ff.flags_one, wm_one,
			nxt_s.wdata, set_one, irq_bank_pkg::FLAGS_ONE_IMPL); // [RULE_03]
		nxt_s.flags_two = update_flags(s_ff.flags_two, wm_two,
			nxt_s.wdata, set_two, irq_bank_pkg::FLAGS_TWO_IMPL); // [RULE_13]
		nxt_s.flags_three = update_flags(s_ff.flags_three, wm_three,
			nxt_s.wdata, set_three,
			irq_bank_pkg::FLAGS_THREE_IMPL); // [RULE_18]
		// Read-only buffer mirrors
		nxt_s.flags_one[irq_bank_pkg::BIT_RX] = serial_one_rx_full; // [RULE_07]
		nxt_s.flags_one[irq_bank_pkg::BIT_TX] = serial_one_tx_empty; // [RULE_08]
		nxt_s.flags_three[irq_bank_pkg::BIT_RX] = serial_two_rx_full; // [RULE_18]
		nxt_s.flags_three[irq_bank_pkg::BIT_TX] = serial_two_tx_empty;

		// Enable and control registers
		if (do_write) begin
			unique case (wsel)
				irq_bank_pkg::SEL_ENABLES_ONE: begin
					nxt_s.enables_one = nxt_s.wdata &
						irq_bank_pkg::ENABLES_ONE_IMPL; // [RULE_19]
				end
				irq_bank_pkg::SEL_ENABLES_TWO: begin
					nxt_s.enables_two = nxt_s.wdata &
						irq_bank_pkg::ENABLES_TWO_IMPL; // [RULE_19]
				end
				irq_bank_pkg::SEL_ENABLES_THREE: begin
					nxt_s.enables_three = nxt_s.wdata &
						irq_bank_pkg::ENABLES_THREE_IMPL;
				end
				irq_bank_pkg::SEL_CORE_CONTROL: begin
					nxt_s.core_control = nxt_s.wdata &
						irq_bank_pkg::CORE_CONTROL_IMPL; // [RULE_21]
				end
				irq_bank_pkg::SEL_MODE_CONTROL: begin
					nxt_s.mode_control = nxt_s.wdata &
						irq_bank_pkg::MODE_CONTROL_IMPL;
				end
				default: begin
				end
			endcase
		end
		// Return restores global enable, core response clears it
		if (core_irq_return) begin
			nxt_s.core_control[irq_bank_pkg::BIT_GLOBAL] = 1'b1; // [RULE_22]
		end
		if (core_irq_taken) begin
			nxt_s.core_control[irq_bank_pkg::BIT_GLOBAL] = 1'b0; // [RULE_22]
		end

		// Read channel
		if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_ff.arready) begin
			rsel = decode(s_axi_araddr);
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = irq_bank_pkg::RESP_OKAY;
			unique case (rsel)
				irq_bank_pkg::SEL_FLAGS_ONE: nxt_s.rdata = s_ff.flags_one;
				irq_bank_pkg::SEL_FLAGS_TWO: nxt_s.rdata = s_ff.flags_two;
				irq_bank_pkg::SEL_FLAGS_THREE: nxt_s.rdata = s_ff.flags_three;
				irq_bank_pkg::SEL_ENABLES_ONE: nxt_s.rdata = s_ff.enables_one;
				irq_bank_pkg::SEL_ENABLES_TWO: nxt_s.rdata = s_ff.enables_two;
				irq_bank_pkg::SEL_ENABLES_THREE:
					nxt_s.rdata = s_ff.enables_three;
				irq_bank_pkg::SEL_CORE_CONTROL:
					nxt_s.rdata = s_ff.core_control;
				irq_bank_pkg::SEL_MODE_CONTROL:
					nxt_s.rdata = s_ff.mode_control;
				default: begin
					nxt_s.rdata = irq_bank_pkg::RESET_BYTE;
					nxt_s.rresp = irq_bank_pkg::RESP_SLVERR;
				end
			endcase
		end
		nxt_s.arready = !nxt_s.rvalid;

		// Combined request from flags and enables
		pending = s_ff.flags_one & s_ff.enables_one; // [RULE_23]
		if (!psp_active) begin
			pending[irq_bank_pkg::BIT_PSP] = 1'b0; // [RULE_05]
		end
		request = (|pending) ||
			(|(s_ff.flags_two & s_ff.enables_two)) ||
			(|(s_ff.flags_three & s_ff.enables_three)); // [RULE_19] [RULE_23]
		if (!s_ff.core_control[irq_bank_pkg::BIT_PRIORITY_ON]) begin
			request = request &&
				s_ff.core_control[irq_bank_pkg::BIT_PERIPH_GLOBAL]; // [RULE_20]
		end
		nxt_s.periph_request = request;
		nxt_s.core_irq = request &&
			s_ff.core_control[irq_bank_pkg::BIT_GLOBAL]; // [RULE_21]
	end

	// ==========================================================
	// Registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from state
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready = s_ff.wready;
	assign s_axi_bvalid = s_ff.bvalid;
	assign s_axi_bresp = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid = s_ff.rvalid;
	assign s_axi_rresp = s_ff.rresp;
	assign s_axi_rdata = {24'h000000, s_ff.rdata};
	assign periph_request = s_ff.periph_request;
	assign core_irq = s_ff.core_irq;

endmodule
`default_nettype wire

// File: irq_event_source.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Peripheral event source model
module irq_event_source (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Requests from the bench, one bit per source
	input wire logic [19:0] fire,
	// Event lines toward the bank
	output logic [19:0] pulse
);
	// Events rise one edge after the request and last while asked
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse <= 20'h00000;
		end else begin
			pulse <= fire;
		end
	end
endmodule
`default_nettype wire

// File: irq_bank_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port-level checker of the flag bank
module irq_bank_assertions (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// Core side
	input wire logic core_irq_taken,
	input wire logic core_irq_return,
	input wire logic periph_request,
	input wire logic core_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Outputs quiet at the first edge after reset
	property p_reset_quiet;
		$rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !periph_request
			&& !core_irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs active right after reset");
	// Core request only with a peripheral request
	property p_irq_needs_req;
		core_irq |-> periph_request;
	endproperty
	a_irq_needs_req: assert property (p_irq_needs_req)
		else $error("core request without peripheral request");
	// Taken blocks the core request
	property p_taken_blocks;
		core_irq_taken ##1 !core_irq_return |=> !core_irq;
	endproperty
	a_taken_blocks: assert property (p_taken_blocks)
		else $error("core request after taken");
	// Upper read bits are zero
	property p_rdata_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_rdata_upper: assert property (p_rdata_upper)
		else $error("read data upper bits set");
	// No new write while a response waits
	property p_b_blocks;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_blocks: assert property (p_b_blocks)
		else $error("write ready during response");
	// No new read while data waits
	property p_r_blocks;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_blocks: assert property (p_r_blocks)
		else $error("read ready during data");
	// Read answered one edge later
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered");
	// Write taken whole answered one edge later
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	property p_write_answer;
		s_write_taken |=> s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer)
		else $error("write not answered");
	// Response drops after its handshake
	property p_b_done;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_done: assert property (p_b_done)
		else $error("response held after handshake");

	// Main scenarios seen
	c_write: cover property (s_write_taken);
	c_irq: cover property ($rose(core_irq));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind peripheral_irq_flag_enable_bank irq_bank_assertions u_chk (.*);
`default_nettype wire

// File: testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Self-checking bench of the flag bank
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, periph_request, core_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, rdv;
	logic i2c_master_transmitting = 1'b0, comparator_out = 1'b0;
	logic serial_one_rx_full = 1'b0, serial_one_tx_empty = 1'b0;
	logic serial_two_rx_full = 1'b0, serial_two_tx_empty = 1'b0;
	logic core_irq_taken = 1'b0, core_irq_return = 1'b0;
	logic [9:0] capcomp_mode = 10'h000;
	logic [19:0] fire = 20'h00000;
	wire logic [19:0] pulse;
	wire logic [4:0] capcomp_capture, capcomp_compare;
	wire logic parallel_port_access, conversion_done, sync_serial_done;
	wire logic timer_two_match, timer_one_overflow, nvm_write_done;
	wire logic bus_collision, low_voltage_detected, timer_three_overflow;
	wire logic timer_four_match;
	int mismatches = 0;
	int n_checks = 0;
	// Flag register and bit of each single event source
	logic [7:0] ofs [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04,
		8'h04, 8'h04, 8'h04, 8'h08};
	logic [7:0] msk [10] = '{8'h80, 8'h40, 8'h08, 8'h02, 8'h01, 8'h10,
		8'h08, 8'h04, 8'h02, 8'h08};

	// Event lines from the source model
	assign {capcomp_compare, capcomp_capture, timer_four_match,
		timer_three_overflow, low_voltage_detected, bus_collision,
		nvm_write_done, timer_one_overflow, timer_two_match,
		sync_serial_done, conversion_done, parallel_port_access} = pulse;

	peripheral_irq_flag_enable_bank #(.HAS_EXT_MEM(1'b1)) dut (.*);
	irq_event_source src (.*);

	// Clock
	always #20 aclk = ~aclk;

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, d, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, e);
		logic [31:0] d;
		logic [1:0] rs;
		rd(a, d, rs);
		chk(nm, {24'h000000, e}, d);
		chk(nm, 32'(irq_bank_pkg::RESP_OKAY), 32'(rs));
	endtask

	task automatic ev(input logic [19:0] m);
		@(posedge aclk);
		fire <= m;
		@(posedge aclk);
		fire <= 20'h00000;
		repeat (3) @(posedge aclk);
	endtask

	// Capture/compare units seen, then cleared
	task automatic cc_chk(input logic hit);
		logic [1:0] rs;
		rchk("unit one", 8'h00, hit ? 8'h04 : 8'h00);
		rchk("unit two", 8'h04, hit ? 8'h01 : 8'h00);
		rchk("units 3-5", 8'h08, hit ? 8'h07 : 8'h00);
		for (int a = 0; a < 12; a += 4) wr(8'(a), 8'h00, rs);
	endtask

	task automatic finish_test;
		$display("Checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int a = 0; a < 32; a += 4) rchk("reset", 8'(a), 8'h00);
		rd(8'h20, rdv, r);
		chk("unmapped rdata", 32'h00000000, rdv);
		chk("unmapped rresp", 32'(irq_bank_pkg::RESP_SLVERR),
			32'(r));
		wr(8'h20, 8'hFF, r);
		chk("unmapped bresp", 32'(irq_bank_pkg::RESP_SLVERR),
			32'(r));
		// Refused events, then every single source
		ev(20'h00041);
		rchk("psp off", 8'h00, 8'h00);
		rchk("coll idle", 8'h04, 8'h00);
		wr(irq_bank_pkg::OFS_MODE_CONTROL, 8'h01, r);
		chk("bresp", 32'(irq_bank_pkg::RESP_OKAY), 32'(r));
		i2c_master_transmitting <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			ev(20'h00001 << i);
			rchk("flag", ofs[i], msk[i]);
			wr(ofs[i], 8'h00, r);
			rchk("cleared", ofs[i], 8'h00);
		end
		for (int m = 0; m < 4; m++) begin
			capcomp_mode <= {5{m[1:0]}};
			ev(20'h07C00);
			cc_chk(m == 1);
			ev(20'hF8000);
			cc_chk(m == 2);
		end
		// Read-only mirrors and unimplemented bits
		{serial_one_rx_full, serial_one_tx_empty} <= 2'b11;
		{serial_two_rx_full, serial_two_tx_empty} <= 2'b11;
		wr(8'h00, 8'h00, r);
		rchk("serial one", 8'h00, 8'h30);
		wr(8'h08, 8'hFF, r);
		rchk("flags three", 8'h08, 8'h3F);
		wr(8'h04, 8'hFF, r);
		rchk("flags two", 8'h04, 8'h5F);
		wr(8'h10, 8'hFF, r);
		rchk("enables two", 8'h10, 8'h5F);
		{serial_one_rx_full, serial_one_tx_empty} <= 2'b00;
		{serial_two_rx_full, serial_two_tx_empty} <= 2'b00;
		for (int a = 0; a < 20; a += 4) wr(8'(a), 8'h00, r);
		comparator_out <= 1'b1;
		repeat (8) @(posedge aclk);
		rchk("comparator", 8'h04, 8'h40);
		wr(8'h04, 8'h00, r);
		// Request gating
		ev(20'h00010);
		wr(8'h0C, 8'h01, r);
		repeat (3) @(posedge aclk);
		chk("gated", 32'h0, 32'(periph_request));
		wr(irq_bank_pkg::OFS_CORE_CONTROL, 8'hC0, r);
		repeat (3) @(posedge aclk);
		chk("request", 32'h1, 32'(periph_request));
		chk("core irq", 32'h1, 32'(core_irq));
		core_irq_taken <= 1'b1;
		@(posedge aclk);
		core_irq_taken <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("taken", 32'h0, 32'(core_irq));
		rchk("core ctl", irq_bank_pkg::OFS_CORE_CONTROL, 8'h40);
		core_irq_return <= 1'b1;
		@(posedge aclk);
		core_irq_return <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("return", 32'h1, 32'(core_irq));
		// Priority levels on: peripheral enable no longer gates
		wr(irq_bank_pkg::OFS_CORE_CONTROL, 8'h81, r);
		repeat (3) @(posedge aclk);
		chk("priority on", 32'h1, 32'(periph_request));
		chk("priority irq", 32'h1, 32'(core_irq));
		wr(8'h0C, 8'h00, r);
		repeat (3) @(posedge aclk);
		chk("disabled", 32'h0, 32'(periph_request));
		// Event on the very edge of a clearing write
		wr(8'h00, 8'h00, r);
		@(posedge aclk);
		fire <= 20'h00010;
		fork
			wr(8'h00, 8'h00, r);
			begin
				@(posedge aclk);
				fire <= 20'h00000;
			end
		join
		rchk("set wins", 8'h00, 8'h01);
		finish_test();
	end
endmodule
`default_nettype wire
